// ---- rtl/status_flags_pkg.sv ----
// constants and types shared by the cpu status flag block
package status_flags_pkg;
   // register indices in the unbanked data space
   localparam logic [7:0] alu_flag_index = 8'h04;
   localparam logic [7:0] timer0_ctrl_index = 8'h05;
   localparam logic [7:0] cpu_state_index = 8'h06;
   // bus byte addresses: four times the index
   localparam logic [7:0] alu_flag_addr = 8'h10;
   localparam logic [7:0] timer0_ctrl_addr = 8'h14;
   localparam logic [7:0] cpu_state_addr = 8'h18;
   // alu flag register fields
   localparam int carry_bit = 0;
   localparam int nibble_bit = 1;
   localparam int zero_bit = 2;
   localparam int range_bit = 3;
   localparam int ptr0_step_lo = 4;
   localparam int ptr1_step_lo = 6;
   localparam logic [7:0] flag_write_mask = 8'hf0;
   // cpu state register fields
   localparam int sleep_bit = 2;
   localparam int watchdog_bit = 3;
   localparam int irq_enable_bit = 4;
   localparam int stack_bit = 5;
   // timer0 control register fields
   localparam int prescale_lo = 1;
   localparam int timer0_edge_bit = 6;
   localparam int source_bit = 5;
   localparam int edge_sel_bit = 7;
   localparam logic [7:0] timer0_write_mask = 8'hfe;
   // values after reset
   localparam logic [7:0] alu_flag_reset = 8'hf0;
   localparam logic [7:0] timer0_ctrl_reset = 8'h00;
   localparam logic [7:0] cpu_state_reset = 8'h2c;
   // pointer step encodings
   localparam logic [1:0] step_dec = 2'b00;
   localparam logic [1:0] step_inc = 2'b01;
   // bus responses
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   typedef enum logic [3:0] {
      op_add, op_add_carry, op_sub, op_inc, op_dec, op_and, op_or, op_xor,
      op_clear, op_rot_right, op_rot_left, op_swap, op_move_w, op_bit_clear,
      op_bit_set
   } alu_op_type;
endpackage : status_flags_pkg

// ---- rtl/flag_alu_if.sv ----
// operand and flag bundle between the flag block and its alu
`timescale 1ns/1ps
`default_nettype none
interface flag_alu_if;
   import status_flags_pkg::*;
   alu_op_type op;
   logic [7:0] a;
   logic [7:0] b;
   logic carry_in;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic carry;
   logic nibble;
   logic zero;
   logic range;
   logic touch_z;
   logic touch_dc;
   logic touch_c;
   logic touch_ov;
   modport core (output op, a, b, carry_in, bit_sel,
                 input result, carry, nibble, zero, range, touch_z, touch_dc, touch_c, touch_ov);
   modport alu (input op, a, b, carry_in, bit_sel,
                output result, carry, nibble, zero, range, touch_z, touch_dc, touch_c, touch_ov);
endinterface : flag_alu_if
`default_nettype wire

// ---- rtl/flag_alu.sv ----
// eight-bit alu producing result and status flags
`timescale 1ns/1ps
`default_nettype none
module flag_alu
   import status_flags_pkg::*;
(
   flag_alu_if.alu f
);
   always_comb
   begin
      logic [7:0] addend;
      logic cin;
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] res;
      addend = f.b;
      cin = 1'b0;
      case (f.op)
         op_add_carry: cin = f.carry_in;
         op_sub:
         begin
            addend = ~f.b;
            cin = 1'b1;
         end
         op_inc:
         begin
            addend = 8'h00;
            cin = 1'b1;
         end
         op_dec: addend = 8'hff;
         default: ;
      endcase
      sum = {1'b0, f.a} + {1'b0, addend} + {8'h00, cin};
      low = {1'b0, f.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
      res = sum[7:0];
      // carry out of the top bit
      f.carry = sum[8];
      // carry out of the low nibble
      f.nibble = low[4];
      // signed overflow flips the sign bit
      f.range = (f.a[7] == addend[7]) && (sum[7] != f.a[7]);
      f.touch_z = 1'b0;
      f.touch_dc = 1'b0;
      f.touch_c = 1'b0;
      f.touch_ov = 1'b0;
      case (f.op)
         op_add, op_add_carry, op_sub, op_inc, op_dec:
         begin
            f.touch_z = 1'b1;
            f.touch_dc = 1'b1;
            f.touch_c = 1'b1;
            f.touch_ov = 1'b1;
         end
         op_and:
         begin
            res = f.a & f.b;
            f.touch_z = 1'b1;
         end
         op_or:
         begin
            res = f.a | f.b;
            f.touch_z = 1'b1;
         end
         op_xor:
         begin
            res = f.a ^ f.b;
            f.touch_z = 1'b1;
         end
         op_clear:
         begin
            res = 8'h00;
            f.touch_z = 1'b1;
         end
         // rotates load carry from the shifted-out bit
         op_rot_right:
         begin
            res = {f.carry_in, f.a[7:1]};
            f.carry = f.a[0];
            f.touch_c = 1'b1;
         end
         op_rot_left:
         begin
            res = {f.a[6:0], f.carry_in};
            f.carry = f.a[7];
            f.touch_c = 1'b1;
         end
         op_swap: res = {f.a[3:0], f.a[7:4]};
         op_move_w: res = f.b;
         op_bit_clear: res = f.a & ~(8'h01 << f.bit_sel);
         op_bit_set: res = f.a | (8'h01 << f.bit_sel);
         default: res = f.a;
      endcase
      f.result = res;
      // zero flag from the final result
      f.zero = (res == 8'h00);
   end
endmodule : flag_alu
`default_nettype wire

// ---- rtl/alu_cpu_status_flags.sv ----
// cpu status flag registers with alu, timer0 control and an axi4-lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - flag writes blocked when instruction sets flags
// - clear to flag register gives 0000u1uu
// - carries mean no-borrow during subtraction
// - overflow set outside -128 to +127
// - overflow means sign bit flipped by magnitude
// - operands from accumulator, file or immediate
// - bits 5-4 step pointer a
// - zero flag follows result being zero
// - carry from top bit, rotates load it
// - global enable gates irq_pending; the external pin edge output is not gated
// - watchdog, sleep, stack bits ignore writes
// - bit 7 picks external pin edge
// - timer0 bits 6-1 set timer0 pin edge, prescale and source; bit 0 ignores writes
// - source bit one picks instruction clock
module alu_cpu_status_flags
   import status_flags_pkg::*;
#(
   parameter int data_width = 32,
   parameter int addr_width = 8
)
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // axi4-lite register slave
   input wire logic [addr_width-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [data_width-1:0] s_axi_wdata,
   input wire logic [data_width/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [addr_width-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [data_width-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // instruction execution port
   input wire logic exec_valid,
   input wire alu_op_type exec_op,
   input wire logic exec_two_operand,
   input wire logic exec_use_imm,
   input wire logic exec_on_file,
   input wire logic [7:0] working_accumulator,
   input wire logic [7:0] file_operand,
   input wire logic [7:0] imm_operand,
   input wire logic [2:0] exec_bit_sel,
   input wire logic exec_dest_file,
   input wire logic [7:0] exec_dest_addr,
   output logic [7:0] exec_result_q,
   // device status events
   input wire logic irq_pending,
   input wire logic stack_room_in,
   input wire logic watchdog_set_evt,
   input wire logic watchdog_clr_evt,
   input wire logic sleep_set_evt,
   input wire logic sleep_clr_evt,
   // pins
   input wire logic ext_interrupt_pin,
   input wire logic timer0_clock_pin,
   // control outputs
   output logic irq_request_q,
   output logic [7:0] ptr_a_delta_q,
   output logic [7:0] ptr_b_delta_q,
   output logic ext_irq_edge_q,
   output logic timer0_tick_q,
   output logic [3:0] timer0_prescale_q,
   output logic [7:0] alu_flags_q
);
   if (data_width != 32 || addr_width < 8)
   begin : g_bad_width
      $error("alu_cpu_status_flags: bus must be 32 data bits and at least 8 address bits");
   end

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] aluf;
      logic [7:0] t0;
      logic [7:0] cpu;
      logic [7:0] result;
      logic irq;
      logic [7:0] pa;
      logic [7:0] pb;
      logic [1:0] ext_sync;
      logic ext_last;
      logic ext_edge;
      logic [1:0] tck_sync;
      logic tck_last;
      logic tick;
   } state_type;

   state_type s_q;
   state_type s_d;
   flag_alu_if f ();

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [1:0] decode_reg(input logic [addr_width-1:0] addr);
      if (addr == addr_width'(alu_flag_addr))
         return 2'd1;
      else if (addr == addr_width'(timer0_ctrl_addr))
         return 2'd2;
      else if (addr == addr_width'(cpu_state_addr))
         return 2'd3;
      else
         return 2'd0;
   endfunction : decode_reg

   function automatic logic [7:0] step_delta(input logic [1:0] mode);
      if (mode == step_dec)
         return 8'hff;
      else if (mode == step_inc)
         return 8'h01;
      else
         return 8'h00;
   endfunction : step_delta

   ////////////////////////////////////////////////////////////////////////
   // alu operand selection

   // single operand on accumulator or file, pair with file or immediate
   assign f.op = exec_op;
   assign f.a = exec_two_operand ? (exec_use_imm ? imm_operand : file_operand)
                                 : (exec_on_file ? file_operand : working_accumulator);
   assign f.b = working_accumulator;
   assign f.carry_in = s_q.aluf[carry_bit];
   assign f.bit_sel = exec_bit_sel;

   flag_alu u_alu (
      .f (f.alu)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic [7:0] wmask;
      logic [7:0] wbyte;
      logic tck_edge;
      wmask = 8'hff;
      wbyte = s_axi_wdata[7:0];
      tck_edge = 1'b0;
      s_d = s_q;

      // bus write: address and data are taken together
      if (s_q.awready)
      begin
         s_d.awready = 1'b0;
         s_d.wready = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = resp_okay;
         if (decode_reg(s_axi_awaddr) == 2'd0)
            s_d.bresp = resp_slverr;
         else if (s_axi_wstrb[0])
         begin
            if (decode_reg(s_axi_awaddr) == 2'd1)
               s_d.aluf = wbyte;
            else if (decode_reg(s_axi_awaddr) == 2'd2)
               s_d.t0 = wbyte & timer0_write_mask;
            else
               s_d.cpu[irq_enable_bit] = wbyte[irq_enable_bit];
         end
      end
      else if (s_axi_awvalid && s_axi_wvalid && !s_q.bvalid)
      begin
         s_d.awready = 1'b1;
         s_d.wready = 1'b1;
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;

      // bus read
      if (s_q.arready)
      begin
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rresp = resp_okay;
         if (decode_reg(s_axi_araddr) == 2'd1)
            s_d.rdata = s_q.aluf;
         else if (decode_reg(s_axi_araddr) == 2'd2)
            s_d.rdata = s_q.t0;
         else if (decode_reg(s_axi_araddr) == 2'd3)
            s_d.rdata = s_q.cpu;
         else
         begin
            s_d.rdata = 8'h00;
            s_d.rresp = resp_slverr;
         end
      end
      else if (s_axi_arvalid && !s_q.rvalid)
         s_d.arready = 1'b1;
      if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;

      // instruction result; applied after the bus so hardware wins a tie
      if (exec_valid)
      begin
         s_d.result = f.result;
         if (exec_dest_file)
         begin
            // status bits stay under flag logic
            if (f.touch_z || f.touch_dc || f.touch_c)
               wmask = flag_write_mask;
            // clear writes only the upper nibble
            if (exec_dest_addr == alu_flag_index)
               s_d.aluf = (s_d.aluf & ~wmask) | (f.result & wmask);
            else if (exec_dest_addr == timer0_ctrl_index)
               s_d.t0 = f.result & timer0_write_mask;
            else if (exec_dest_addr == cpu_state_index)
               s_d.cpu[irq_enable_bit] = f.result[irq_enable_bit];
         end
         if (f.touch_z)
            s_d.aluf[zero_bit] = f.zero;
         if (f.touch_dc)
            s_d.aluf[nibble_bit] = f.nibble;
         if (f.touch_c)
            s_d.aluf[carry_bit] = f.carry;
         if (f.touch_ov)
            s_d.aluf[range_bit] = f.range;
      end

      // device-owned status; a set beats a clear
      s_d.cpu[stack_bit] = stack_room_in;
      if (watchdog_set_evt)
         s_d.cpu[watchdog_bit] = 1'b1;
      else if (watchdog_clr_evt)
         s_d.cpu[watchdog_bit] = 1'b0;
      if (sleep_set_evt)
         s_d.cpu[sleep_bit] = 1'b1;
      else if (sleep_clr_evt)
         s_d.cpu[sleep_bit] = 1'b0;

      // one gate for irq_pending; ext_irq_edge_q is not gated
      s_d.irq = irq_pending && s_q.cpu[irq_enable_bit];

      s_d.pa = step_delta(s_q.aluf[ptr0_step_lo +: 2]);
      s_d.pb = step_delta(s_q.aluf[ptr1_step_lo +: 2]);

      // pins pass two flops before anything looks at them
      s_d.ext_sync = {s_q.ext_sync[0], ext_interrupt_pin};
      s_d.ext_last = s_q.ext_sync[1];
      s_d.tck_sync = {s_q.tck_sync[0], timer0_clock_pin};
      s_d.tck_last = s_q.tck_sync[1];

      // edge select for the external interrupt
      if (s_q.t0[edge_sel_bit])
         s_d.ext_edge = s_q.ext_sync[1] && !s_q.ext_last;
      else
         s_d.ext_edge = !s_q.ext_sync[1] && s_q.ext_last;

      // timer0 pin edge follows its own edge bit
      if (s_q.t0[timer0_edge_bit])
         tck_edge = s_q.tck_sync[1] && !s_q.tck_last;
      else
         tck_edge = !s_q.tck_sync[1] && s_q.tck_last;
      // source select, instruction clock or pin
      s_d.tick = s_q.t0[source_bit] ? 1'b1 : tck_edge;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_q <= '0;
         s_q.aluf <= alu_flag_reset;
         s_q.t0 <= timer0_ctrl_reset;
         s_q.cpu <= cpu_state_reset;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rdata = {24'h000000, s_q.rdata};
   assign exec_result_q = s_q.result;
   assign irq_request_q = s_q.irq;
   assign ptr_a_delta_q = s_q.pa;
   assign ptr_b_delta_q = s_q.pb;
   assign ext_irq_edge_q = s_q.ext_edge;
   assign timer0_tick_q = s_q.tick;
   // prescale ratio straight from the control bits
   assign timer0_prescale_q = s_q.t0[prescale_lo +: 4];
   assign alu_flags_q = s_q.aluf;

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic signed [9:0] wide_sum;
   logic flag_dest;
   assign wide_sum = $signed({f.a[7], f.a[7], f.a}) + $signed({f.b[7], f.b[7], f.b});
   assign flag_dest = exec_valid && exec_dest_file && (exec_dest_addr == alu_flag_index);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   chk_flag_write_mask: assert property (
      flag_dest && !s_q.awready && (f.touch_z || f.touch_dc || f.touch_c) |=> s_q.aluf[carry_bit]
         == ($past(f.touch_c) ? $past(f.carry) : $past(s_q.aluf[carry_bit])))
      else $error("carry bit took the written value");
   chk_clear_flag: assert property (
      flag_dest && exec_op == op_clear |=> s_q.aluf[7:4] == 4'h0 && s_q.aluf[zero_bit]
         && s_q.aluf[range_bit] == $past(s_q.aluf[range_bit])
         && s_q.aluf[1:0] == $past(s_q.aluf[1:0]))
      else $error("clear of flag register wrong");
   chk_sub_borrow: assert property (
      exec_valid && exec_op == op_sub |=> s_q.aluf[carry_bit] == ($past(f.a) >= $past(f.b)))
      else $error("subtract carry is not no-borrow");
   chk_signed_range: assert property (
      exec_valid && exec_op == op_add |=> s_q.aluf[range_bit] == ($past(wide_sum) > 127
         || $past(wide_sum) < -128))
      else $error("overflow flag wrong");
   chk_zero_flag: assert property (
      exec_valid && f.touch_z |=> s_q.aluf[zero_bit] == ($past(f.result) == 8'h00))
      else $error("zero flag wrong");
   chk_nibble_carry: assert property (
      exec_valid && exec_op == op_add |=> s_q.aluf[nibble_bit]
         == (({1'b0, $past(f.a[3:0])} + {1'b0, $past(f.b[3:0])}) > 5'd15))
      else $error("nibble carry wrong");
   chk_ptr_a_step: assert property (
      s_q.aluf[5:4] == 2'b00 |=> ptr_a_delta_q == 8'hff)
      else $error("pointer a not decrementing");
   chk_ptr_b_step: assert property (
      s_q.aluf[7:6] == 2'b01 |=> ptr_b_delta_q == 8'h01)
      else $error("pointer b not incrementing");
   chk_irq_gate: assert property (
      !s_q.cpu[irq_enable_bit] |=> !irq_request_q)
      else $error("request passed a closed gate");
   chk_status_fixed: assert property (
      !watchdog_set_evt && !watchdog_clr_evt |=> $stable(s_q.cpu[watchdog_bit]))
      else $error("watchdog bit changed without event");
   chk_ext_edge: assert property (
      s_q.t0[edge_sel_bit] && s_q.ext_sync[1] && !s_q.ext_last |=> ext_irq_edge_q)
      else $error("rising edge missed");
   chk_t0_source: assert property (
      s_q.t0[source_bit] |=> timer0_tick_q)
      else $error("instruction clock tick missing");
endmodule : alu_cpu_status_flags
`default_nettype wire

// ---- test/alu_cpu_status_flags_tb_top.sv ----
// self-checking bench for the cpu status flag block over axi4-lite and the instruction port
`timescale 1ns/1ps
`default_nettype none
module alu_cpu_status_flags_tb_top
   import status_flags_pkg::*;
;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic ev = 1'b0, two = 1'b0, dfile = 1'b0;
   alu_op_type op = op_add;
   logic [7:0] acc = 8'h00, opnd = 8'h00, daddr = 8'h00;
   logic [7:0] res, pa, pb, flags;
   logic irq_pend = 1'b0, sleep_clr = 1'b0, pin = 1'b0;
   logic onf = 1'b1, stk = 1'b1, wd_clr = 1'b0;
   logic irq_req, edge_q, tick;
   logic [3:0] prescale;
   int n_mismatch = 0;
   int total_checks = 0;
   logic [1:0] r;
   logic [7:0] d;

   always #50 clock = ~clock;

   alu_cpu_status_flags alu_cpu_status_flags_inst (
      .clock(clock), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .exec_valid(ev), .exec_op(op), .exec_two_operand(two), .exec_use_imm(1'b1), .exec_on_file(onf),
      .working_accumulator(acc), .file_operand(opnd), .imm_operand(opnd), .exec_bit_sel(3'h7),
      .exec_dest_file(dfile), .exec_dest_addr(daddr), .exec_result_q(res),
      .irq_pending(irq_pend), .stack_room_in(stk), .watchdog_set_evt(1'b0), .watchdog_clr_evt(wd_clr),
      .sleep_set_evt(1'b0), .sleep_clr_evt(sleep_clr),
      .ext_interrupt_pin(pin), .timer0_clock_pin(1'b0),
      .irq_request_q(irq_req), .ptr_a_delta_q(pa), .ptr_b_delta_q(pb), .ext_irq_edge_q(edge_q),
      .timer0_tick_q(tick), .timer0_prescale_q(prescale), .alu_flags_q(flags)
   );

   ////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
      begin
         $display("*** PASS ***");
      end
      else
      begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // master holds each channel until its ready edge, then the response handshake
   task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clock); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge clock);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [7:0] v, output logic [1:0] resp);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock);
      check(rdata[31:8], 24'h0);
      v = rdata[7:0];
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] v);
      axi_read(a, d, r);
      check(r, resp_okay);
      check(d, v);
   endtask : expect_reg

   // one instruction; result and flags land at the edge that takes it
   task automatic exec(input alu_op_type o, input logic t, input logic [7:0] a, input logic [7:0] b,
                       input logic df, input logic [7:0] er, input logic [7:0] ef);
      @(posedge clock);
      ev <= 1'b1;
      op <= o;
      two <= t;
      opnd <= a;
      acc <= b;
      dfile <= df;
      daddr <= alu_flag_index;
      @(posedge clock);
      ev <= 1'b0;
      #1;
      check(res, er);
      check(flags, ef);
   endtask : exec

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      test_done();
   end

   initial
   begin
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      expect_reg(alu_flag_addr, alu_flag_reset);
      expect_reg(timer0_ctrl_addr, timer0_ctrl_reset);
      expect_reg(cpu_state_addr, cpu_state_reset);
      axi_read(8'h20, d, r);
      check({r, d}, {resp_slverr, 8'h00});
      axi_write(8'h1c, 8'hff, r);
      check(r, resp_slverr);
      // step encodings for both pointers: 00 down, 01 up, 1x hold
      for (int i = 0; i < 4; i++)
      begin
         axi_write(alu_flag_addr, 8'(i * 'h50), r);
         repeat (3) @(posedge clock);
         check(pa, (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'h00);
         check(pb, (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'h00);
      end
      // only the global enable is writable; device bits stay
      axi_write(cpu_state_addr, 8'hd3, r);
      expect_reg(cpu_state_addr, 8'h3c);
      axi_write(cpu_state_addr, 8'h00, r);
      irq_pend <= 1'b1;
      repeat (3) @(posedge clock);
      check(irq_req, 1'b0);
      axi_write(cpu_state_addr, 8'h10, r);
      repeat (3) @(posedge clock);
      check(irq_req, 1'b1);
      @(posedge clock);
      sleep_clr <= 1'b1;
      @(posedge clock);
      sleep_clr <= 1'b0;
      expect_reg(cpu_state_addr, 8'h38);
      // stack room follows its input, watchdog clears on its event
      stk <= 1'b0;
      wd_clr <= 1'b1;
      @(posedge clock);
      wd_clr <= 1'b0;
      expect_reg(cpu_state_addr, 8'h10);
      axi_write(timer0_ctrl_addr, 8'hff, r);
      expect_reg(timer0_ctrl_addr, 8'hfe);
      check(prescale, 4'hf);
      check(tick, 1'b1);
      axi_write(timer0_ctrl_addr, 8'h80, r);
      repeat (3) @(posedge clock);
      check(tick, 1'b0);
      @(posedge clock);
      pin <= 1'b1;
      d = 8'h00;
      repeat (8)
      begin
         @(posedge clock);
         #1;
         d = d + 8'(edge_q);
      end
      check(d, 8'h01);
      axi_write(alu_flag_addr, 8'h40, r);
      // flag table: arithmetic, no-borrow sense, overflow, logic and rotates
      exec(op_add, 1'b1, 8'h7f, 8'h01, 1'b0, 8'h80, 8'h4a);
      exec(op_add, 1'b1, 8'hff, 8'h01, 1'b0, 8'h00, 8'h47);
      exec(op_sub, 1'b1, 8'h05, 8'h05, 1'b0, 8'h00, 8'h47);
      exec(op_sub, 1'b1, 8'h03, 8'h05, 1'b0, 8'hfe, 8'h40);
      exec(op_sub, 1'b1, 8'h80, 8'h01, 1'b0, 8'h7f, 8'h49);
      exec(op_add, 1'b1, 8'h08, 8'h08, 1'b0, 8'h10, 8'h42);
      exec(op_and, 1'b1, 8'h0f, 8'hf0, 1'b0, 8'h00, 8'h46);
      exec(op_rot_left, 1'b0, 8'h80, 8'h00, 1'b0, 8'h00, 8'h47);
      // single operand now taken from the accumulator
      @(posedge clock);
      onf <= 1'b0;
      exec(op_rot_right, 1'b0, 8'h00, 8'h01, 1'b0, 8'h80, 8'h47);
      // flag register as destination: low flags the op touches come from the alu, the rest hold; all from the result for op_move_w
      exec(op_clear, 1'b0, 8'haa, 8'h00, 1'b1, 8'h00, 8'h07);
      exec(op_and, 1'b1, 8'hf8, 8'hf8, 1'b1, 8'hf8, 8'hf3);
      exec(op_add, 1'b1, 8'h30, 8'h27, 1'b1, 8'h57, 8'h50);
      exec(op_move_w, 1'b0, 8'h00, 8'h35, 1'b1, 8'h35, 8'h35);
      expect_reg(alu_flag_addr, 8'h35);
      test_done();
   end
endmodule : alu_cpu_status_flags_tb_top
`default_nettype wire
